// *** rtl/pdm_ctrl.sv ***
// power-down mode controller with an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl #(
	parameter int WAIT_8K   = 8192,
	parameter int WAIT_16K  = 16384,
	parameter int WAIT_32K  = 32768,
	parameter int WAIT_64K  = 65536,
	parameter int WAIT_128K = 131072
) (
	// clock and reset
	input  wire logic                     CLK_SYS_I,
	input  wire logic                     RST_I,
	// axi4-lite write address and data
	input  wire logic                     S_AXI_AWVALID_I,
	output logic                          S_AXI_AWREADY_O,
	input  wire logic [7:0]               S_AXI_AWADDR_I,
	input  wire logic                     S_AXI_WVALID_I,
	output logic                          S_AXI_WREADY_O,
	input  wire logic [31:0]              S_AXI_WDATA_I,
	input  wire logic [3:0]               S_AXI_WSTRB_I,
	// axi4-lite write response
	output logic                          S_AXI_BVALID_O,
	input  wire logic                     S_AXI_BREADY_I,
	output logic [1:0]                    S_AXI_BRESP_O,
	// axi4-lite read
	input  wire logic                     S_AXI_ARVALID_I,
	output logic                          S_AXI_ARREADY_O,
	input  wire logic [7:0]               S_AXI_ARADDR_I,
	output logic                          S_AXI_RVALID_O,
	input  wire logic                     S_AXI_RREADY_I,
	output logic [31:0]                   S_AXI_RDATA_O,
	output logic [1:0]                    S_AXI_RRESP_O,
	// cpu core
	input  wire logic                     SLEEP_I,
	input  wire logic                     IRQ_MASK_I,
	output logic                          CPU_RESET_O,
	output logic                          EXC_START_O,
	// wake sources and reset pin, asynchronous
	input  wire logic [pdm_pkg::IRQ_W-1:0] IRQ_REQ_I,
	input  wire logic                     RESET_INPUT_LOW_N_I,
	// clock and pin gating
	output logic [3:0]                    MODE_O,
	output logic                          CPU_CLK_EN_O,
	output logic                          PERI_CLK_EN_O,
	output logic                          WATCH_PERI_EN_O,
	output logic                          OSC_EN_O,
	output logic                          PIN_HIZ_O,
	output logic [1:0]                    CPU_CLK_SEL_O,
	output logic [1:0]                    MED_DIV_O,
	output logic [1:0]                    SUB_DIV_LOG2_O,
	output logic                          NOISE_SEL_O
);
	pdm_pkg::pdm_state_t state_q;
	pdm_pkg::pdm_state_t state_d;
	pdm_pkg::pdm_state_t target_q;
	pdm_pkg::pdm_state_t target_d;

	logic [7:0]                ctrl_one_q;
	logic [7:0]                ctrl_two_q;
	logic [7:0]                timer_mode_q;
	logic [pdm_pkg::IRQ_W-1:0] wake_en_q;
	logic                      from_stby_q;
	logic                      from_stby_d;
	logic                      exc_d;
	logic                      start_d;

	logic [pdm_pkg::IRQ_W-1:0] irq_sync;
	logic                      rst_pin_sync;
	logic                      pin_reset;
	logic                      settle_busy;
	logic                      settle_done;
	logic [17:0]               settle_load;

	logic                      aw_hs;
	logic                      ar_hs;

	// control bit views
	logic       standby_select;
	logic       low_speed_wake_select;
	logic       medium_speed_select;
	logic       direct_transfer_select;
	logic       timer_watch_select;
	logic [2:0] settle_wait_sel;

	assign standby_select         = ctrl_one_q[pdm_pkg::BIT_STANDBY_SEL];
	assign low_speed_wake_select  = ctrl_one_q[pdm_pkg::BIT_LOW_SPEED];
	assign settle_wait_sel        = ctrl_one_q[pdm_pkg::POS_SETTLE_SEL +: 3];
	assign medium_speed_select    = ctrl_two_q[pdm_pkg::BIT_MED_SPEED];
	assign direct_transfer_select = ctrl_two_q[pdm_pkg::BIT_DIRECT];
	assign timer_watch_select     = timer_mode_q[pdm_pkg::BIT_TIMER_WATCH];

	// wake requests and reset pin come from outside the clock domain
	pdm_sync3 #(.WIDTH(pdm_pkg::IRQ_W)) u_irq_sync (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.async_i(IRQ_REQ_I),
		.sync_o (irq_sync)
	);

	pdm_sync3 #(.WIDTH(1)) u_rst_sync (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.async_i(RESET_INPUT_LOW_N_I),
		.sync_o (rst_pin_sync)
	);

	// synchroniser resets to 0, so the pin reads as asserted until it is seen high
	assign pin_reset = ~rst_pin_sync;

	// wake is refused under the cpu mask or a cleared source enable
	logic [pdm_pkg::IRQ_W-1:0] wake_req;
	assign wake_req = IRQ_MASK_I ? '0 : (irq_sync & wake_en_q);

	always_comb begin
		unique case (settle_wait_sel)
			3'h0:    settle_load = 18'(WAIT_8K);
			3'h1:    settle_load = 18'(WAIT_16K);
			3'h2:    settle_load = 18'(WAIT_32K);
			3'h3:    settle_load = 18'(WAIT_64K);
			3'h4:    settle_load = 18'(WAIT_128K);
			3'h5:    settle_load = pdm_pkg::WAIT_2;
			3'h6:    settle_load = pdm_pkg::WAIT_8;
			default: settle_load = pdm_pkg::WAIT_16;
		endcase
	end

	pdm_settle_timer #(.CNT_W(18)) u_settle (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.start_i(start_d),
		.load_i (settle_load),
		.busy_o (settle_busy),
		.done_o (settle_done)
	);

	// mode sequencing
	always_comb begin
		state_d     = state_q;
		target_d    = target_q;
		from_stby_d = from_stby_q;
		exc_d       = 1'b0;
		start_d     = 1'b0;
		unique case (state_q)
			pdm_pkg::ST_RESET: begin
				if (!pin_reset) begin
					state_d = pdm_pkg::ST_HIGH;
				end
			end
			pdm_pkg::ST_HIGH, pdm_pkg::ST_MED: begin
				if (SLEEP_I) begin
					if (direct_transfer_select && !standby_select && !low_speed_wake_select
							&& (medium_speed_select == (state_q == pdm_pkg::ST_HIGH))) begin
						state_d = medium_speed_select ? pdm_pkg::ST_MED : pdm_pkg::ST_HIGH;
						exc_d   = 1'b1;
					end else if (direct_transfer_select && standby_select && timer_watch_select
							&& low_speed_wake_select) begin
						state_d = pdm_pkg::ST_SUB;
						exc_d   = 1'b1;
					end else if (!standby_select && !low_speed_wake_select) begin
						// high and medium sleep take effect on this edge, ahead of the nominal point
						state_d = medium_speed_select ? pdm_pkg::ST_SLEEP_M
							: pdm_pkg::ST_SLEEP_H;
					end else if (standby_select && timer_watch_select) begin
						state_d = pdm_pkg::ST_WATCH;
					end else if (standby_select && !low_speed_wake_select) begin
						state_d = pdm_pkg::ST_STANDBY;
					end
				end
			end
			pdm_pkg::ST_SUB: begin
				if (SLEEP_I && standby_select && timer_watch_select) begin
					if (direct_transfer_select && !low_speed_wake_select) begin
						state_d     = pdm_pkg::ST_SETTLE;
						target_d    = medium_speed_select ? pdm_pkg::ST_MED : pdm_pkg::ST_HIGH;
						from_stby_d = 1'b0;
						start_d     = 1'b1;
					end else begin
						state_d = pdm_pkg::ST_WATCH;
					end
				end
			end
			pdm_pkg::ST_SLEEP_H, pdm_pkg::ST_SLEEP_M: begin
				if (|(wake_req & pdm_pkg::SRC_SLEEP)) begin
					state_d = (state_q == pdm_pkg::ST_SLEEP_M) ? pdm_pkg::ST_MED
						: pdm_pkg::ST_HIGH;
					exc_d   = 1'b1;
				end
			end
			pdm_pkg::ST_STANDBY: begin
				if (|(wake_req & pdm_pkg::SRC_STANDBY)) begin
					state_d     = pdm_pkg::ST_SETTLE;
					target_d    = medium_speed_select ? pdm_pkg::ST_MED : pdm_pkg::ST_HIGH;
					from_stby_d = 1'b1;
					start_d     = 1'b1;
				end
			end
			pdm_pkg::ST_WATCH: begin
				if (|(wake_req & pdm_pkg::SRC_WATCH)) begin
					if (low_speed_wake_select) begin
						state_d = pdm_pkg::ST_SUB;
						exc_d   = 1'b1;
					end else begin
						state_d     = pdm_pkg::ST_SETTLE;
						target_d    = medium_speed_select ? pdm_pkg::ST_MED : pdm_pkg::ST_HIGH;
						from_stby_d = 1'b0;
						start_d     = 1'b1;
					end
				end
			end
			pdm_pkg::ST_SETTLE: begin
				if (settle_done) begin
					state_d = target_q;
					exc_d   = 1'b1;
				end
			end
		endcase
		// the reset pin overrides every mode, sleeping or not
		if (pin_reset) begin
			state_d = pdm_pkg::ST_RESET;
			exc_d   = 1'b0;
			start_d = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			state_q     <= pdm_pkg::ST_RESET;
			target_q    <= pdm_pkg::ST_HIGH;
			from_stby_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			target_q    <= target_d;
			from_stby_q <= from_stby_d;
		end
	end

	// registered mode outputs, all but the exception start (from exc_d) taken from the next state
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			MODE_O          <= pdm_pkg::MODE_RESET;
			CPU_CLK_EN_O    <= 1'b1;
			PERI_CLK_EN_O   <= 1'b1;
			WATCH_PERI_EN_O <= 1'b1;
			OSC_EN_O        <= 1'b1;
			PIN_HIZ_O       <= 1'b0;
			CPU_RESET_O     <= 1'b1;
			CPU_CLK_SEL_O   <= pdm_pkg::CLK_SEL_FULL;
			EXC_START_O     <= 1'b0;
		end else begin
			EXC_START_O     <= exc_d;
			CPU_RESET_O     <= (state_d == pdm_pkg::ST_RESET);
			CPU_CLK_EN_O    <= state_d inside {pdm_pkg::ST_RESET, pdm_pkg::ST_HIGH,
				pdm_pkg::ST_MED, pdm_pkg::ST_SUB};
			PERI_CLK_EN_O   <= state_d inside {pdm_pkg::ST_RESET, pdm_pkg::ST_HIGH,
				pdm_pkg::ST_MED, pdm_pkg::ST_SUB, pdm_pkg::ST_SLEEP_H, pdm_pkg::ST_SLEEP_M};
			// only the watch-domain timers, event counter and lcd survive watch
			WATCH_PERI_EN_O <= !(state_d == pdm_pkg::ST_STANDBY
				|| (state_d == pdm_pkg::ST_SETTLE && from_stby_d));
			OSC_EN_O        <= !(state_d inside {pdm_pkg::ST_STANDBY, pdm_pkg::ST_WATCH,
				pdm_pkg::ST_SUB});
			// pins stay released until standby is fully cleared
			PIN_HIZ_O       <= (state_d == pdm_pkg::ST_STANDBY)
				|| (state_d == pdm_pkg::ST_SETTLE && from_stby_d);
			unique case (state_d)
				pdm_pkg::ST_MED, pdm_pkg::ST_SLEEP_M: CPU_CLK_SEL_O <= pdm_pkg::CLK_SEL_MED;
				pdm_pkg::ST_SUB, pdm_pkg::ST_WATCH:   CPU_CLK_SEL_O <= pdm_pkg::CLK_SEL_SUB;
				default:                              CPU_CLK_SEL_O <= pdm_pkg::CLK_SEL_FULL;
			endcase
			unique case (state_d)
				pdm_pkg::ST_RESET:   MODE_O <= pdm_pkg::MODE_RESET;
				pdm_pkg::ST_HIGH:    MODE_O <= pdm_pkg::MODE_HIGH;
				pdm_pkg::ST_MED:     MODE_O <= pdm_pkg::MODE_MED;
				pdm_pkg::ST_SUB:     MODE_O <= pdm_pkg::MODE_SUB;
				pdm_pkg::ST_SLEEP_H: MODE_O <= pdm_pkg::MODE_SLEEP_H;
				pdm_pkg::ST_SLEEP_M: MODE_O <= pdm_pkg::MODE_SLEEP_M;
				pdm_pkg::ST_STANDBY: MODE_O <= pdm_pkg::MODE_STANDBY;
				pdm_pkg::ST_WATCH:   MODE_O <= pdm_pkg::MODE_WATCH;
				default:             MODE_O <= pdm_pkg::MODE_SETTLE;
			endcase
		end
	end

	// register writes; a chip reset through the pin also restores them
	assign aw_hs = S_AXI_AWREADY_O & S_AXI_AWVALID_I;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_one_q   <= pdm_pkg::CTRL_ONE_RST;
			ctrl_two_q   <= pdm_pkg::CTRL_TWO_RST;
			timer_mode_q <= pdm_pkg::TIMER_MODE_RST;
			wake_en_q    <= pdm_pkg::WAKE_EN_RST;
		end else if (pin_reset) begin
			ctrl_one_q   <= pdm_pkg::CTRL_ONE_RST;
			ctrl_two_q   <= pdm_pkg::CTRL_TWO_RST;
			timer_mode_q <= pdm_pkg::TIMER_MODE_RST;
			wake_en_q    <= pdm_pkg::WAKE_EN_RST;
		end else if (aw_hs) begin
			unique case (S_AXI_AWADDR_I)
				pdm_pkg::OFS_CTRL_ONE: begin
					if (S_AXI_WSTRB_I[0]) begin
						ctrl_one_q <= S_AXI_WDATA_I[7:0] | pdm_pkg::CTRL_ONE_FIX;
					end
				end
				pdm_pkg::OFS_CTRL_TWO: begin
					if (S_AXI_WSTRB_I[0]) begin
						ctrl_two_q[7:2] <= S_AXI_WDATA_I[7:2] | pdm_pkg::CTRL_TWO_FIX[7:2];
						if (state_q != pdm_pkg::ST_SUB) begin
							ctrl_two_q[1:0] <= S_AXI_WDATA_I[1:0];
						end
					end
				end
				pdm_pkg::OFS_TIMER_MODE: begin
					if (S_AXI_WSTRB_I[0]) begin
						timer_mode_q <= S_AXI_WDATA_I[7:0];
					end
				end
				pdm_pkg::OFS_WAKE_EN: begin
					if (S_AXI_WSTRB_I[0]) begin
						wake_en_q[7:0] <= S_AXI_WDATA_I[7:0];
					end
					if (S_AXI_WSTRB_I[1]) begin
						wake_en_q[15:8] <= S_AXI_WDATA_I[15:8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// divider outputs follow the stored selects
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			MED_DIV_O      <= pdm_pkg::CTRL_ONE_RST[1:0];
			SUB_DIV_LOG2_O <= pdm_pkg::SUB_LOG2_DIV8;
			NOISE_SEL_O    <= pdm_pkg::CTRL_TWO_RST[pdm_pkg::BIT_NOISE_SEL];
		end else begin
			MED_DIV_O   <= ctrl_one_q[pdm_pkg::POS_MED_DIV +: 2];
			NOISE_SEL_O <= ctrl_two_q[pdm_pkg::BIT_NOISE_SEL];
			if (ctrl_two_q[pdm_pkg::POS_SUB_DIV + 1]) begin
				SUB_DIV_LOG2_O <= pdm_pkg::SUB_LOG2_DIV2;
			end else if (ctrl_two_q[pdm_pkg::POS_SUB_DIV]) begin
				SUB_DIV_LOG2_O <= pdm_pkg::SUB_LOG2_DIV4;
			end else begin
				SUB_DIV_LOG2_O <= pdm_pkg::SUB_LOG2_DIV8;
			end
		end
	end

	// write channel: address and data are taken together, one write in flight
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= pdm_pkg::RESP_OKAY;
		end else begin
			S_AXI_AWREADY_O <= !S_AXI_AWREADY_O && !S_AXI_BVALID_O
				&& S_AXI_AWVALID_I && S_AXI_WVALID_I;
			S_AXI_WREADY_O  <= !S_AXI_AWREADY_O && !S_AXI_BVALID_O
				&& S_AXI_AWVALID_I && S_AXI_WVALID_I;
			if (aw_hs) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= (S_AXI_AWADDR_I inside {pdm_pkg::OFS_CTRL_ONE,
					pdm_pkg::OFS_CTRL_TWO, pdm_pkg::OFS_TIMER_MODE, pdm_pkg::OFS_WAKE_EN,
					pdm_pkg::OFS_STATUS}) ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_DECERR;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// read channel
	assign ar_hs = S_AXI_ARREADY_O & S_AXI_ARVALID_I;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= 32'h00000000;
			S_AXI_RRESP_O   <= pdm_pkg::RESP_OKAY;
		end else begin
			S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O && S_AXI_ARVALID_I;
			if (ar_hs) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RRESP_O  <= pdm_pkg::RESP_OKAY;
				unique case (S_AXI_ARADDR_I)
					pdm_pkg::OFS_CTRL_ONE:   S_AXI_RDATA_O <= {24'h000000, ctrl_one_q};
					pdm_pkg::OFS_CTRL_TWO:   S_AXI_RDATA_O <= {24'h000000, ctrl_two_q};
					pdm_pkg::OFS_TIMER_MODE: S_AXI_RDATA_O <= {24'h000000, timer_mode_q};
					pdm_pkg::OFS_WAKE_EN:    S_AXI_RDATA_O <= {16'h0000, wake_en_q};
					pdm_pkg::OFS_STATUS:     S_AXI_RDATA_O <= {27'h0000000, settle_busy, MODE_O};
					default: begin
						S_AXI_RDATA_O <= 32'h00000000;
						S_AXI_RRESP_O <= pdm_pkg::RESP_DECERR;
					end
				endcase
			end else if (S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/pdm_pkg.sv ***
// shared constants for the power-down mode controller
package pdm_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
	localparam logic [7:0] OFS_TIMER_MODE = 8'h08;
	localparam logic [7:0] OFS_WAKE_EN    = 8'h0c;
	localparam logic [7:0] OFS_STATUS     = 8'h10;

	// system_control_one fields
	localparam int BIT_STANDBY_SEL = 7;
	localparam int POS_SETTLE_SEL  = 4;
	localparam int BIT_LOW_SPEED   = 3;
	localparam int POS_MED_DIV     = 0;
	localparam logic [7:0] CTRL_ONE_RST = 8'h07;
	localparam logic [7:0] CTRL_ONE_FIX = 8'h04;

	// system_control_two fields
	localparam int BIT_NOISE_SEL   = 4;
	localparam int BIT_DIRECT      = 3;
	localparam int BIT_MED_SPEED   = 2;
	localparam int POS_SUB_DIV     = 0;
	localparam logic [7:0] CTRL_TWO_RST = 8'hf0;
	localparam logic [7:0] CTRL_TWO_FIX = 8'he0;

	// timer_a_mode_reg field
	localparam int BIT_TIMER_WATCH = 3;
	localparam logic [7:0] TIMER_MODE_RST = 8'h00;

	// wake request lines: 0/1 external, 2..9 wake-up pins, 10..12 timers a/f/g, rest other
	localparam int IRQ_W = 16;
	localparam logic [15:0] WAKE_EN_RST    = 16'h0000;
	localparam logic [15:0] SRC_SLEEP      = 16'hffff;
	localparam logic [15:0] SRC_STANDBY    = 16'h03ff;
	localparam logic [15:0] SRC_WATCH      = 16'h1ffd;

	// short settling waits in states (clock cycles)
	localparam logic [17:0] WAIT_2  = 18'h00002;
	localparam logic [17:0] WAIT_8  = 18'h00008;
	localparam logic [17:0] WAIT_16 = 18'h00010;

	// subactive divider as log2 of the ratio
	localparam logic [1:0] SUB_LOG2_DIV8 = 2'h3;
	localparam logic [1:0] SUB_LOG2_DIV4 = 2'h2;
	localparam logic [1:0] SUB_LOG2_DIV2 = 2'h1;

	// cpu clock source select
	localparam logic [1:0] CLK_SEL_FULL = 2'h0;
	localparam logic [1:0] CLK_SEL_MED  = 2'h1;
	localparam logic [1:0] CLK_SEL_SUB  = 2'h2;

	// mode codes on the mode output and in the status register
	localparam logic [3:0] MODE_RESET   = 4'h0;
	localparam logic [3:0] MODE_HIGH    = 4'h1;
	localparam logic [3:0] MODE_MED     = 4'h2;
	localparam logic [3:0] MODE_SUB     = 4'h3;
	localparam logic [3:0] MODE_SLEEP_H = 4'h4;
	localparam logic [3:0] MODE_SLEEP_M = 4'h5;
	localparam logic [3:0] MODE_STANDBY = 4'h6;
	localparam logic [3:0] MODE_WATCH   = 4'h7;
	localparam logic [3:0] MODE_SETTLE  = 4'h8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [8:0] {
		ST_RESET   = 9'h001,
		ST_HIGH    = 9'h002,
		ST_MED     = 9'h004,
		ST_SUB     = 9'h008,
		ST_SLEEP_H = 9'h010,
		ST_SLEEP_M = 9'h020,
		ST_STANDBY = 9'h040,
		ST_WATCH   = 9'h080,
		ST_SETTLE  = 9'h100
	} pdm_state_t;

endpackage

// *** rtl/pdm_sync3.sv ***
// three-stage synchroniser that accepts a level once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pdm_sync3 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] held_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit holds its last agreed value while stages two and three differ
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			held_q <= '0;
		end else begin
			held_q <= sync_o;
		end
	end

	assign sync_o = (s2_q & s3_q) | (held_q & (s2_q | s3_q));
endmodule
`default_nettype wire

// *** rtl/pdm_settle_timer.sv ***
// oscillator settling wait counter
`timescale 1ns/10ps
`default_nettype none
module pdm_settle_timer #(
	parameter int CNT_W = 18
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             start_i,
	input  wire logic [CNT_W-1:0] load_i,
	output logic                  busy_o,
	output logic                  done_o
);
	logic [CNT_W-1:0] cnt_q;
	logic             busy_q;
	logic             done_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start_i) begin
				cnt_q  <= load_i - CNT_W'(1);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q == '0) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - CNT_W'(1);
				end
			end
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
endmodule
`default_nettype wire

// *** tb/pdm_ctrl_monitor.sv ***
// port assertions for the power-down mode controller
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl_monitor (
	input wire logic       CLK_SYS_I,
	input wire logic       RST_I,
	input wire logic       IRQ_MASK_I,
	input wire logic       RESET_INPUT_LOW_N_I,
	input wire logic       EXC_START_O,
	input wire logic       CPU_CLK_EN_O,
	input wire logic       WATCH_PERI_EN_O,
	input wire logic       PERI_CLK_EN_O,
	input wire logic       OSC_EN_O,
	input wire logic       PIN_HIZ_O,
	input wire logic       CPU_RESET_O,
	input wire logic [3:0] MODE_O,
	input wire logic [1:0] CPU_CLK_SEL_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	a_sleep_halts: assert property (
		MODE_O inside {4'h4, 4'h5} |-> !CPU_CLK_EN_O && PERI_CLK_EN_O)
		else $error("sleep gating wrong");
	a_standby_pins: assert property (
		MODE_O == 4'h6 |-> PIN_HIZ_O && !OSC_EN_O && !PERI_CLK_EN_O)
		else $error("standby gating wrong");
	a_watch_clock: assert property (
		MODE_O == 4'h7 |-> CPU_CLK_SEL_O == 2'h2 && !OSC_EN_O)
		else $error("watch clocking wrong");
	a_watch_peri: assert property (
		MODE_O == 4'h7 |-> WATCH_PERI_EN_O && !PERI_CLK_EN_O)
		else $error("watch peripheral gating wrong");
	// mask and pin held long enough to cover both synchronisers
	a_mask_holds: assert property (
		(IRQ_MASK_I && RESET_INPUT_LOW_N_I)[*5] ##0 MODE_O inside {4'h4, 4'h5}
		|=> MODE_O == $past(MODE_O))
		else $error("masked wake left sleep");
	a_sleep_wake: assert property (
		MODE_O inside {4'h1, 4'h2} && $past(MODE_O) inside {4'h4, 4'h5}
		|-> EXC_START_O && MODE_O == $past(MODE_O) - 4'h3)
		else $error("sleep wake wrong");
	a_pin_reset: assert property (
		(!RESET_INPUT_LOW_N_I)[*5] |-> MODE_O == 4'h0 && CPU_RESET_O)
		else $error("pin reset not taken");
	a_settle_exit: assert property (
		$past(MODE_O) == 4'h8 && MODE_O inside {4'h1, 4'h2} |-> EXC_START_O)
		else $error("settle exit without exception");
	a_exc_pulse: assert property (EXC_START_O |=> !EXC_START_O)
		else $error("exception start too long");
endmodule
bind pdm_ctrl pdm_ctrl_monitor i_mon (.*);
`default_nettype wire

// *** tb/pdm_cpu_model.sv ***
// cpu core and wake source model facing the mode controller
`timescale 1ns/10ps
`default_nettype none
module pdm_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        sleep_i,
	input  wire logic        mask_i,
	input  wire logic        pin_n_i,
	input  wire logic [15:0] irq_i,
	output logic             sleep_o,
	output logic             mask_o,
	output logic             pin_n_o,
	output logic [15:0]      irq_o
);
	initial {sleep_o, mask_o, pin_n_o, irq_o} = 19'h30000;
	// all inputs are passed on as levels one clock later; nothing is latched until serviced
	always @(posedge clk_i) begin
		sleep_o <= sleep_i;
		mask_o <= mask_i;
		pin_n_o <= pin_n_i;
		irq_o <= irq_i;
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the power-down mode controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk, rst, awv, wv, br, arv, rr, slp, msk, pin, s_slp, s_msk, s_pin;
	logic [7:0]  aw, ar;
	logic [31:0] wd;
	logic [15:0] irq, s_irq;
	logic [3:0]  ws;
	wire logic   awr, wr, bv, arr, rv, hiz;
	wire logic [1:0]  bresp, rresp, sub, md;
	wire logic [31:0] rd;
	wire logic [3:0]  mode;
	int          err_count = 0, checks_done = 0, n;
	pdm_cpu_model i_pdm_cpu_model (.clk_i(clk), .sleep_i(slp), .mask_i(msk), .pin_n_i(pin),
		.irq_i(irq), .sleep_o(s_slp), .mask_o(s_msk), .pin_n_o(s_pin), .irq_o(s_irq));
	// settle waits shortened so the long codes finish quickly
	pdm_ctrl #(.WAIT_8K(20), .WAIT_16K(24), .WAIT_32K(28), .WAIT_64K(32), .WAIT_128K(36)) i_pdm_ctrl (
		.CLK_SYS_I(clk), .RST_I(rst), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_AWADDR_I(aw), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ar), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp), .SLEEP_I(s_slp),
		.IRQ_MASK_I(s_msk), .CPU_RESET_O(), .EXC_START_O(), .IRQ_REQ_I(s_irq),
		.RESET_INPUT_LOW_N_I(s_pin), .MODE_O(mode), .CPU_CLK_EN_O(), .PERI_CLK_EN_O(),
		.WATCH_PERI_EN_O(), .OSC_EN_O(), .PIN_HIZ_O(hiz), .CPU_CLK_SEL_O(), .MED_DIV_O(md),
		.SUB_DIV_LOG2_O(sub), .NOISE_SEL_O());
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic lim(input bit bad);
		if (bad) begin
			err_count++;
			results();
		end
	endtask
	task automatic wm(input logic [3:0] m);
		for (n = 0; mode !== m && n < 300; n++) @(posedge clk);
		lim(mode !== m);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		{awv, wv, br, aw, wd} <= {3'b111, a, d};
		for (n = 0; !(awr && wr) && n < 50; n++) @(posedge clk);
		lim(n == 50);
		{awv, wv} <= 2'b00;
		for (n = 0; !bv && n < 50; n++) @(posedge clk);
		br <= 0;
		lim(n == 50);
		chk(bresp, r);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		{arv, rr, ar} <= {2'b11, a};
		for (n = 0; !arr && n < 50; n++) @(posedge clk);
		lim(n == 50);
		arv <= 0;
		for (n = 0; !rv && n < 50; n++) @(posedge clk);
		rr <= 0;
		lim(n == 50);
		chk(rd, d);
		chk(rresp, r);
	endtask
	task automatic sleep();
		@(posedge clk);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
	endtask
	task automatic t_regs();
		rd_reg(8'h00, 32'h07, 2'h0);
		rd_reg(8'h04, 32'hf0, 2'h0);
		rd_reg(8'h14, 32'h0, 2'h3);
		chk(sub, 2'h3);
		chk(md, 2'h3);
		ws <= 4'he;
		wr_reg(8'h00, 32'h0, 2'h0);
		ws <= 4'hf;
		rd_reg(8'h00, 32'h07, 2'h0);
		for (int i = 1; i < 4; i++) begin
			wr_reg(8'h04, i, 2'h0);
			// the divider output follows the stored field one clock later
			@(posedge clk);
			chk(sub, i == 1 ? 2'h2 : 2'h1);
		end
		wr_reg(8'h04, 32'h0, 2'h0);
		wr_reg(8'h0c, 32'h0407, 2'h0);
		$display("register test done");
	endtask
	task automatic t_sleep();
		for (int m = 0; m < 2; m++) begin
			wr_reg(8'h04, 32'hf0 | m << 2, 2'h0);
			sleep();
			wm(4'h4 + m);
			irq <= 16'h1;
			repeat (10) @(posedge clk);
			chk(mode, 4'h4 + m);
			irq <= 0;
			repeat (5) @(posedge clk);
			msk <= 0;
			repeat (5) @(posedge clk);
			chk(mode, 4'h4 + m);
			irq <= 16'h1;
			wm(4'h1 + m);
			chk(n <= 6, 1);
			{irq, msk} <= 17'h1;
		end
		$display("sleep test done");
	endtask
	task automatic t_stby();
		for (int i = 0; i < 2; i++) begin
			wr_reg(8'h00, i ? 32'h87 : 32'he7, 2'h0);
			wr_reg(8'h04, i ? 32'hf0 : 32'hf4, 2'h0);
			sleep();
			wm(4'h6);
			chk(hiz, 1);
			{irq, msk} <= 17'h8;
			wm(4'h8);
			wm(4'h2 - i);
			chk(n >= (i ? 20 : 8) && n < (i ? 26 : 14), 1);
			{irq, msk} <= 17'h1;
		end
		$display("standby test done");
	endtask
	task automatic t_watch();
		wr_reg(8'h08, 32'h8, 2'h0);
		wr_reg(8'h00, 32'hef, 2'h0);
		sleep();
		wm(4'h7);
		{irq, msk} <= 17'h4;
		repeat (10) @(posedge clk);
		chk(mode, 4'h7);
		irq <= 16'h400;
		wm(4'h3);
		wr_reg(8'h04, 32'h1, 2'h0);
		rd_reg(8'h04, 32'he0, 2'h0);
		chk(sub, 2'h3);
		irq <= 0;
		wr_reg(8'h00, 32'he7, 2'h0);
		sleep();
		wm(4'h7);
		irq <= 16'h400;
		wm(4'h8);
		wm(4'h1);
		irq <= 0;
		$display("watch test done");
	endtask
	task automatic t_pin();
		wr_reg(8'h00, 32'h07, 2'h0);
		sleep();
		wm(4'h4);
		pin <= 0;
		wm(4'h0);
		repeat (8) @(posedge clk);
		pin <= 1;
		wm(4'h1);
		rd_reg(8'h08, 32'h0, 2'h0);
		wr_reg(8'h04, 32'h0c, 2'h0);
		sleep();
		wm(4'h2);
		$display("pin reset test done");
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst = 1;
		{awv, wv, br, arv, rr, slp, msk, pin, aw, ar, wd, irq} = 72'h030000000000000000;
		ws = 4'hf;
		repeat (6) @(posedge clk);
		rst <= 0;
		wm(4'h1);
		t_regs();
		t_sleep();
		t_stby();
		t_watch();
		t_pin();
		results();
	end
endmodule
`default_nettype wire
